//--- inc/cdeleg_pkg.sv
// Constants, types and register map of the counter delegation checker
package cdeleg_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses, one 32-bit word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNTEREN = 8'h08;
  localparam logic [7:0] OFS_MINHIBIT = 8'h0C;
  localparam logic [7:0] OFS_SISEL = 8'h10;
  localparam logic [7:0] OFS_VSISEL = 8'h14;
  localparam logic [7:0] OFS_DELEGATED = 8'h18;
  localparam logic [7:0] OFS_OVF_IRQ_BASE = 8'h20;
  localparam int OVF_IRQ_REGS = 8;

  // ---------------------------------------------------------------
  // Control register fields and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_CDE = 0;
  localparam int CTRL_MSTATE = 1;
  localparam int CTRL_HSTATE = 2;
  localparam int CTRL_XLEN64 = 3;
  localparam logic [3:0] CTRL_RESET = 4'h6;
  localparam logic [31:0] COUNTEREN_RESET = 32'h0000_0000;
  localparam logic [31:0] MINHIBIT_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Indirect select range and window layout
  // ---------------------------------------------------------------
  localparam logic [31:0] SEL_FIRST = 32'h0000_0040;
  localparam logic [31:0] SEL_LAST = 32'h0000_005F;
  localparam logic [4:0] IDX_CYCLE = 5'h00;
  localparam logic [4:0] IDX_TIME = 5'h01;
  localparam logic [4:0] IDX_INSTRET = 5'h02;
  localparam int INHIBIT_BIT = 62;
  localparam int OVF_BIT = 63;
  localparam int OVF_IRQ_BIT = 13;

  // Overflow interrupt register slots
  localparam int LC_MVIP = 0;
  localparam int LC_MVIEN = 1;
  localparam int LC_HVIP = 2;
  localparam int LC_HVIEN = 3;
  localparam int LC_VSIE = 4;
  localparam int LC_VSIP = 5;
  localparam int LC_MIDELEG = 6;
  localparam int LC_HIDELEG = 7;

  // Privilege encodings
  localparam logic [1:0] PRIV_U = 2'h0;
  localparam logic [1:0] PRIV_S = 2'h1;
  localparam logic [1:0] PRIV_M = 2'h3;

  typedef enum logic [2:0] {
    TGT_SEL = 3'h0,
    TGT_WIN = 3'h1,
    TGT_VSEL = 3'h2,
    TGT_VWIN = 3'h3,
    TGT_SCINH = 3'h4,
    TGT_SCOVF = 3'h5
  } acc_target_e;

  typedef struct packed {
    logic valid;
    acc_target_e target;
    logic [2:0] win;
    logic [1:0] priv;
    logic virt;
    logic write;
    logic [63:0] wdata;
  } acc_req_s;

  typedef struct packed {
    logic valid;
    logic illegal;
    logic virt_fault;
    logic [63:0] rdata;
  } acc_resp_s;

endpackage : cdeleg_pkg

//--- core/local_overflow_irq_bit.sv
// One interrupt register whose only implementable bit is the overflow bit
`timescale 1ns/10ps
module local_overflow_irq_bit #(
  parameter bit IMPL = 1'b1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Write port
  input wire logic wr_en,
  input wire logic [31:0] wdata,
  // Read view
  output logic [31:0] rdata
);

  logic bit_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      bit_reg <= 1'b0;
    end else if (wr_en && IMPL) begin
      bit_reg <= wdata[cdeleg_pkg::OVF_IRQ_BIT];
    end
  end

  // Unimplemented copies read as zero
  always_comb begin
    rdata = 32'h0000_0000;
    rdata[cdeleg_pkg::OVF_IRQ_BIT] = bit_reg & IMPL;
  end

endmodule : local_overflow_irq_bit

//--- core/counter_delegation_access.sv
// Counter delegation access checker with indirect window aliasing
//
// Function
// R1 - Select 0x40+i, up to 0x5F, names counter i; needs both enables.
// R2 - Windows 1/4 reach counter low/high; 2/5 reach selector low/high.
// R3 - M/S window access in delegated range traps illegal if delegation off.
// R4 - Windows 3 and 6 trap illegal in delegated range.
// R5 - Windows 4 and 5 trap illegal in delegated range at 64-bit width.
// R6 - Select 0x41 or non-enabled counter traps illegal on any window.
// R7 - Window state needing an absent feature traps illegal from M/S.
// R8 - State-enable bit 60 blocks lower modes first; later checks follow.
// R9 - Guest direct access to guest pair, guest user to supervisor: virtual.
// R10 - Guest window from M/S with guest select in range traps illegal.
// R11 - Guest S-mode window in range: illegal if delegation off, else virtual.
// R12 - Machine count inhibit bit 62 reads zero, keeps value, via windows.
// R13 - Supervisor halt register is a masked alias of the machine one.
// R14 - Supervisor halt access traps illegal while delegation off.
// R15 - Supervisor halt access from guest modes traps virtual when enabled.
// R16 - Guest read of overflow view traps virtual when all features enabled.
// R17 - Bit 13 writable in machine virtual pending and enable registers.
// R18 - Bit 13 writable in hypervisor virtual pending and enable registers.
// R19 - Bit 13 implemented in guest interrupt enable and pending registers.
// R20 - Bit 13 in interrupt delegation registers is optional.
// R21 - Counter access-enable bits grant reads and mark delegated counters.
`timescale 1ns/10ps
module counter_delegation_access #(
  parameter bit HAS_H = 1'b1,
  parameter bit HAS_CNTR = 1'b1,
  parameter bit HAS_HPM = 1'b1,
  parameter bit HAS_OVF = 1'b1,
  parameter bit HAS_FILT = 1'b1,
  parameter bit HAS_AIA = 1'b1,
  parameter bit HAS_IDELEG = 1'b0,
  parameter int NUM_CTR = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // CSR access request and answer
  input wire cdeleg_pkg::acc_req_s acc_req,
  output cdeleg_pkg::acc_resp_s acc_resp
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [3:0] ctrl_reg;
  logic [31:0] counteren_reg;
  logic [31:0] minhibit_reg;
  logic [31:0] sisel_reg;
  logic [31:0] vsisel_reg;
  logic [31:0] reg_rdata_reg;
  cdeleg_pkg::acc_resp_s resp_reg;
  logic [63:0] cnt_mem [0:NUM_CTR-1];
  logic [63:0] evt_mem [0:NUM_CTR-1];

  wire cde = ctrl_reg[cdeleg_pkg::CTRL_CDE];
  wire mstate_ok = ctrl_reg[cdeleg_pkg::CTRL_MSTATE];
  wire hstate_ok = ctrl_reg[cdeleg_pkg::CTRL_HSTATE];
  wire xlen64 = ctrl_reg[cdeleg_pkg::CTRL_XLEN64];

  // Counters handed to supervisor mode
  wire [31:0] delegated = cde ? counteren_reg : 32'h0000_0000; // R21

  // ---------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------
  wire req_v = acc_req.valid;
  wire [1:0] priv = acc_req.priv;
  wire virt = acc_req.virt && HAS_H;
  wire is_m = priv == cdeleg_pkg::PRIV_M;
  wire is_u = priv == cdeleg_pkg::PRIV_U;
  wire t_sel = acc_req.target == cdeleg_pkg::TGT_SEL;
  wire t_win = acc_req.target == cdeleg_pkg::TGT_WIN;
  wire t_vsel = acc_req.target == cdeleg_pkg::TGT_VSEL;
  wire t_vwin = acc_req.target == cdeleg_pkg::TGT_VWIN;
  wire t_scinh = acc_req.target == cdeleg_pkg::TGT_SCINH;
  wire t_scovf = acc_req.target == cdeleg_pkg::TGT_SCOVF;
  wire t_ind_s = t_sel || t_win;
  wire t_ind_v = t_vsel || t_vwin;
  wire [2:0] win = acc_req.win;

  // Guest accesses to the supervisor pair really reach the guest pair
  wire [31:0] eff_sel = virt ? vsisel_reg : sisel_reg;
  wire [31:0] win_sel = t_vwin ? vsisel_reg : eff_sel;
  wire in_rng = win_sel >= cdeleg_pkg::SEL_FIRST
                && win_sel <= cdeleg_pkg::SEL_LAST; // R1
  wire vs_in_rng = vsisel_reg >= cdeleg_pkg::SEL_FIRST
                   && vsisel_reg <= cdeleg_pkg::SEL_LAST;
  wire [4:0] idx = win_sel[4:0]; // R1
  wire idx_base = idx == cdeleg_pkg::IDX_CYCLE
                  || idx == cdeleg_pkg::IDX_INSTRET;
  wire win_ctr = win == 3'h1 || win == 3'h4;
  wire win_evt = win == 3'h2 || win == 3'h5;

  // ---------------------------------------------------------------
  // Fault checks
  // ---------------------------------------------------------------
  // Plain user mode never reaches supervisor-level registers
  wire f_priv = !virt && is_u;
  // Guest registers need the hypervisor
  wire f_noh = !HAS_H && t_ind_v;
  wire blk_m = !mstate_ok && !is_m && (t_ind_s || t_ind_v); // R8
  wire blk_h = virt && !hstate_ok && t_ind_s; // R8
  wire v_direct = virt && (t_ind_v || (is_u && t_ind_s)); // R9

  // Missing feature behind the selected state
  wire f_feat = (idx_base && !HAS_CNTR)
                || (idx_base && win_evt && !HAS_FILT)
                || (!idx_base && !HAS_HPM)
                || (!idx_base && win == 3'h5 && !HAS_OVF); // R7

  wire ms_win = !virt && t_win && in_rng;
  wire f_win_ms = ms_win && (!cde // R3
                  || win == 3'h3 || win == 3'h6 // R4
                  || (xlen64 && (win == 3'h4 || win == 3'h5)) // R5
                  || idx == cdeleg_pkg::IDX_TIME // R6
                  || !counteren_reg[idx] // R6
                  || f_feat); // R7
  wire f_vwin = !virt && t_vwin && vs_in_rng; // R10
  wire vs_win = virt && !is_u && t_win && vs_in_rng;
  wire f_vs_ill = vs_win && !cde; // R11
  wire f_vs_virt = vs_win && cde; // R11
  wire f_scinh_ill = t_scinh && !cde; // R14
  wire f_scinh_virt = t_scinh && cde && virt; // R15
  wire f_scovf_virt = t_scovf && HAS_OVF && cde && virt; // R16
  wire f_scovf_wr = t_scovf && acc_req.write;

  // Blocking by state enable is judged before anything else
  wire illegal = f_priv || f_noh || blk_m
                 || (!blk_h && !v_direct
                     && (f_win_ms || f_vwin || f_vs_ill
                         || f_scinh_ill || f_scovf_wr)); // R8
  wire virt_fault = !illegal && (blk_h || v_direct || f_vs_virt
                                 || f_scinh_virt || f_scovf_virt); // R8
  wire ok = req_v && !illegal && !virt_fault;

  // ---------------------------------------------------------------
  // Window data path
  // ---------------------------------------------------------------
  localparam logic [63:0] INHIBIT_MASK = 64'h1 << cdeleg_pkg::INHIBIT_BIT;
  wire [63:0] cnt_q = cnt_mem[idx];
  wire [63:0] evt_q = evt_mem[idx] & ~INHIBIT_MASK; // R12
  wire [63:0] wd = acc_req.wdata;
  wire win_live = t_win && in_rng && (virt ? 1'b0 : 1'b1);

  logic [63:0] win_rd;
  always_comb begin
    win_rd = 64'h0000_0000_0000_0000;
    case (win)
      3'h1: win_rd = xlen64 ? cnt_q : {32'h0000_0000, cnt_q[31:0]}; // R2
      3'h4: win_rd = {32'h0000_0000, cnt_q[63:32]}; // R2
      3'h2: win_rd = xlen64 ? evt_q : {32'h0000_0000, evt_q[31:0]}; // R2
      3'h5: win_rd = {32'h0000_0000, evt_q[63:32]}; // R12
      default: win_rd = 64'h0000_0000_0000_0000;
    endcase
  end

  // Next value of an event selector keeps the hidden inhibit bit
  logic [63:0] evt_next;
  logic [63:0] cnt_next;
  always_comb begin
    evt_next = evt_mem[idx];
    cnt_next = cnt_mem[idx];
    if (win == 3'h2) begin
      evt_next = xlen64 ? wd : {evt_mem[idx][63:32], wd[31:0]};
    end else if (win == 3'h5) begin
      evt_next = {wd[31:0], evt_mem[idx][31:0]};
    end
    evt_next = (evt_next & ~INHIBIT_MASK) | (evt_mem[idx] & INHIBIT_MASK); // R12
    if (win == 3'h1) begin
      cnt_next = xlen64 ? wd : {cnt_mem[idx][63:32], wd[31:0]};
    end else if (win == 3'h4) begin
      cnt_next = {wd[31:0], cnt_mem[idx][31:0]};
    end
  end

  // Overflow view: overflow flags of delegated counters only
  logic [31:0] ovf_view;
  always_comb begin
    ovf_view = 32'h0000_0000;
    for (int i = 0; i < NUM_CTR; i++) begin
      ovf_view[i] = evt_mem[i][cdeleg_pkg::OVF_BIT] & delegated[i];
    end
  end

  wire [31:0] scinh_rd = minhibit_reg & delegated; // R13

  logic [63:0] acc_rd;
  always_comb begin
    acc_rd = 64'h0000_0000_0000_0000;
    if (t_sel) begin
      acc_rd = {32'h0000_0000, eff_sel};
    end else if (t_vsel) begin
      acc_rd = {32'h0000_0000, vsisel_reg};
    end else if (win_live || (t_vwin && vs_in_rng)) begin
      acc_rd = win_rd;
    end else if (t_scinh) begin
      acc_rd = {32'h0000_0000, scinh_rd};
    end else if (t_scovf) begin
      acc_rd = {32'h0000_0000, ovf_view};
    end
  end

  wire acc_wr = ok && acc_req.write;
  wire win_wr = acc_wr && (win_live || (t_vwin && vs_in_rng))
                && (win_ctr || win_evt);

  // ---------------------------------------------------------------
  // Register port decode
  // ---------------------------------------------------------------
  wire wr_ctrl = reg_wr && reg_addr == cdeleg_pkg::OFS_CTRL;
  wire wr_cen = reg_wr && reg_addr == cdeleg_pkg::OFS_COUNTEREN;
  wire wr_machine_mode_count_inhibit = reg_wr && reg_addr == cdeleg_pkg::OFS_MINHIBIT;
  wire lc_hit = reg_addr[7:5] == cdeleg_pkg::OFS_OVF_IRQ_BASE[7:5];
  wire [2:0] lc_idx = reg_addr[4:2];
  wire scinh_wr = acc_wr && t_scinh;

  // Implemented overflow interrupt copies
  wire lc_m = HAS_OVF && HAS_AIA; // R17
  wire lc_h = lc_m && HAS_H; // R18
  logic [cdeleg_pkg::OVF_IRQ_REGS-1:0] lc_impl;
  always_comb begin
    lc_impl = '0;
    lc_impl[cdeleg_pkg::LC_MVIP] = lc_m; // R17
    lc_impl[cdeleg_pkg::LC_MVIEN] = lc_m; // R17
    lc_impl[cdeleg_pkg::LC_HVIP] = lc_h; // R18
    lc_impl[cdeleg_pkg::LC_HVIEN] = lc_h; // R18
    lc_impl[cdeleg_pkg::LC_VSIE] = lc_h; // R19
    lc_impl[cdeleg_pkg::LC_VSIP] = lc_h; // R19
    lc_impl[cdeleg_pkg::LC_MIDELEG] = HAS_IDELEG; // R20
    lc_impl[cdeleg_pkg::LC_HIDELEG] = HAS_IDELEG && HAS_H; // R20
  end

  logic [31:0] lc_rd [0:cdeleg_pkg::OVF_IRQ_REGS-1];
  genvar g;
  generate
    for (g = 0; g < cdeleg_pkg::OVF_IRQ_REGS; g++) begin : g_lc
      local_overflow_irq_bit #(
        .IMPL(1'b1)
      ) u_lc (
        .clock(clock),
        .rst(rst),
        .wr_en(reg_wr && lc_hit && lc_idx == g && lc_impl[g]),
        .wdata(reg_wdata),
        .rdata(lc_rd[g])
      );
    end
  endgenerate

  logic [31:0] reg_rd_mux;
  always_comb begin
    reg_rd_mux = 32'h0000_0000;
    if (lc_hit) begin
      reg_rd_mux = lc_rd[lc_idx];
    end else begin
      case (reg_addr)
        cdeleg_pkg::OFS_CTRL: reg_rd_mux = {28'h000_0000, ctrl_reg};
        cdeleg_pkg::OFS_COUNTEREN: reg_rd_mux = counteren_reg;
        cdeleg_pkg::OFS_MINHIBIT: reg_rd_mux = minhibit_reg;
        cdeleg_pkg::OFS_SISEL: reg_rd_mux = sisel_reg;
        cdeleg_pkg::OFS_VSISEL: reg_rd_mux = vsisel_reg;
        cdeleg_pkg::OFS_DELEGATED: reg_rd_mux = delegated; // R21
        default: reg_rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_reg <= cdeleg_pkg::CTRL_RESET;
      counteren_reg <= cdeleg_pkg::COUNTEREN_RESET;
      reg_rdata_reg <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= reg_wdata[3:0];
      end
      if (wr_cen) begin
        counteren_reg <= reg_wdata;
      end
      reg_rdata_reg <= reg_rd ? reg_rd_mux : 32'h0000_0000;
    end
  end

  // Masked alias changes only delegated bits of the machine halt; a register port write replaces all of it unless an alias write comes in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      minhibit_reg <= cdeleg_pkg::MINHIBIT_RESET;
    end else if (scinh_wr) begin
      minhibit_reg <= (minhibit_reg & ~delegated)
                      | (wd[31:0] & delegated); // R13
    end else if (wr_machine_mode_count_inhibit) begin
      minhibit_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sisel_reg <= 32'h0000_0000;
      vsisel_reg <= 32'h0000_0000;
    end else if (acc_wr && t_sel && !virt) begin
      sisel_reg <= wd[31:0];
    end else if (acc_wr && (t_vsel || (t_sel && virt))) begin
      vsisel_reg <= wd[31:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < NUM_CTR; i++) begin
        cnt_mem[i] <= 64'h0000_0000_0000_0000;
        evt_mem[i] <= 64'h0000_0000_0000_0000;
      end
    end else if (win_wr) begin
      cnt_mem[idx] <= cnt_next; // R2
      evt_mem[idx] <= evt_next; // R12
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      resp_reg <= '0;
    end else begin
      resp_reg.valid <= req_v;
      resp_reg.illegal <= req_v && illegal;
      resp_reg.virt_fault <= req_v && virt_fault;
      resp_reg.rdata <= (ok && !acc_req.write) ? acc_rd
                        : 64'h0000_0000_0000_0000;
    end
  end

  assign reg_rdata = reg_rdata_reg;
  assign acc_resp = resp_reg;

endmodule : counter_delegation_access

//--- sim/counter_delegation_access_sva.sv
// Checker for the counter delegation access block
`timescale 1ns/10ps
module counter_delegation_access_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Access port
  input wire cdeleg_pkg::acc_req_s acc_req,
  input wire cdeleg_pkg::acc_resp_s acc_resp
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // Shadow of control bits and both selects
  // ---------------------------------------------------------------
  logic [3:0] ctrl_reg;
  logic [31:0] sel_reg;
  logic [31:0] vsel_reg;
  wire q = acc_req.valid;
  wire v = acc_req.virt;
  wire [2:0] w = acc_req.win;
  wire ill = acc_resp.illegal;
  wire vf = acc_resp.virt_fault;
  wire cde = ctrl_reg[0];
  wire guest = q && v && !acc_req.priv[1];
  wire s_mode = acc_req.priv == cdeleg_pkg::PRIV_S;
  wire ms_ok = acc_req.priv == cdeleg_pkg::PRIV_M || s_mode && ctrl_reg[1];
  wire g_ok = s_mode && ctrl_reg[1] && ctrl_reg[2];
  wire tsel = acc_req.target == cdeleg_pkg::TGT_SEL;
  wire twin = acc_req.target == cdeleg_pkg::TGT_WIN;
  wire thalt = acc_req.target == cdeleg_pkg::TGT_SCINH;
  wire tvsel = acc_req.target == cdeleg_pkg::TGT_VSEL;
  wire in_rng = sel_reg[31:5] == 27'h2;
  wire vin_rng = vsel_reg[31:5] == 27'h2;
  wire swin = q && !v && ms_ok && twin && in_rng;
  wire gwin = q && v && g_ok && twin && vin_rng;
  wire sel_wr = q && acc_req.write && tsel && !v && ms_ok;
  wire vsel_wr = q && acc_req.write
    && (tvsel && !v && ms_ok || tsel && v && g_ok);
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_reg <= cdeleg_pkg::CTRL_RESET;
      sel_reg <= 32'h0;
      vsel_reg <= 32'h0;
    end else begin
      if (reg_wr && reg_addr == cdeleg_pkg::OFS_CTRL) begin
        ctrl_reg <= reg_wdata[3:0];
      end
      if (sel_wr) begin
        sel_reg <= acc_req.wdata[31:0];
      end
      if (vsel_wr) begin
        vsel_reg <= acc_req.wdata[31:0];
      end
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  cde_off_a: assert property (swin && !cde |=> ill)
    else $error("window open while delegation off");
  win_unused_a: assert property (swin
    && (w == 3'h3 || w == 3'h6) |=> ill)
    else $error("unused window not refused");
  wide_high_a: assert property (swin && ctrl_reg[3] && w inside {3'h4, 3'h5}
    |=> ill)
    else $error("high window open at 64-bit width");
  time_sel_a: assert property (swin && sel_reg[4:0] == 5'h01 |=> ill)
    else $error("time index not refused");
  state_block_a: assert property (q && !v && s_mode && !ctrl_reg[1]
    && (tsel || twin) |=> ill && !vf)
    else $error("state enable did not block");
  guest_ms_a: assert property (q && !v && ms_ok && vin_rng
    && acc_req.target == cdeleg_pkg::TGT_VWIN |=> ill)
    else $error("guest window open from host mode");
  guest_win_a: assert property (gwin
    |=> ($past(cde) ? vf && !ill : ill && !vf))
    else $error("wrong trap for guest window");
  inhibit_hide_a: assert property (q && !acc_req.write && twin && w == 3'h5
    && !ctrl_reg[3] |=> !acc_resp.rdata[30])
    else $error("inhibit bit visible through window");
  halt_off_a: assert property (q && !v && ms_ok && thalt && !cde ##1 1'b1
    |-> ill)
    else $error("halt alias open while delegation off");
  halt_guest_a: assert property (guest && thalt && cde |=> vf && !ill)
    else $error("guest halt alias not virtual");
  ovf_guest_a: assert property (guest && !acc_req.write && cde
    && acc_req.target == cdeleg_pkg::TGT_SCOVF |=> vf)
    else $error("guest overflow read not virtual");
  resp_pulse_a: assert property (q |=> acc_resp.valid)
    else $error("access answer missing");
endmodule : counter_delegation_access_sva

bind counter_delegation_access counter_delegation_access_sva sva_u (
  .clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .acc_req, .acc_resp
);

//--- sim/tb_counter_delegation_access.sv
// Self-checking testbench for the counter delegation access block
`timescale 1ns/10ps
module tb_counter_delegation_access;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  cdeleg_pkg::acc_req_s acc_req = '0;
  cdeleg_pkg::acc_resp_s acc_resp;
  cdeleg_pkg::acc_resp_s r;
  int n_fail = 0;
  int n_checks = 0;

  always #5 clock = ~clock;

  // Filtering absent, so filter-backed window state has to trap
  counter_delegation_access #(.HAS_FILT(1'b0)) dut_u (
    .clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .acc_req, .acc_resp
  );

  task automatic chk(input string what, input logic [63:0] exp,
    input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tr(input logic ill, input logic vf);
    chk("answer valid", 64'h1, {63'h0, r.valid});
    chk("illegal", {63'h0, ill}, {63'h0, r.illegal});
    chk("virtual fault", {63'h0, vf}, {63'h0, r.virt_fault});
  endtask : tr

  task automatic rw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : rw

  task automatic rr(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk("register", {32'h0, e}, {32'h0, reg_rdata});
  endtask : rr

  task automatic ac(input cdeleg_pkg::acc_target_e t, input logic [2:0] w,
    input logic [1:0] p, input logic v, input logic wr, input logic [63:0] d);
    @(posedge clock);
    acc_req <= '{1'b1, t, w, p, v, wr, d};
    @(posedge clock);
    acc_req.valid <= 1'b0;
    #1;
    r = acc_resp;
  endtask : ac

  task automatic ck(input cdeleg_pkg::acc_target_e t, input logic [1:0] p,
    input logic v, input logic ill, input logic vf);
    ac(t, 3'h1, p, v, 1'b0, 64'h0);
    tr(ill, vf);
  endtask : ck

  task automatic sw(input logic [2:0] w, input logic [63:0] d);
    ac(cdeleg_pkg::TGT_WIN, w, cdeleg_pkg::PRIV_S, 1'b0, 1'b1, d);
    tr(1'b0, 1'b0);
  endtask : sw

  task automatic sr(input logic [2:0] w, input logic ill,
    input logic [63:0] e);
    ac(cdeleg_pkg::TGT_WIN, w, cdeleg_pkg::PRIV_S, 1'b0, 1'b0, 64'h0);
    tr(ill, 1'b0);
    chk("window", e, r.rdata);
  endtask : sr

  task automatic sel(input logic [63:0] s);
    ac(cdeleg_pkg::TGT_SEL, 3'h0, cdeleg_pkg::PRIV_M, 1'b0, 1'b1, s);
  endtask : sel

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (2000) @(posedge clock);
    n_fail++;
    summarize();
  end

  initial begin
    logic [7:0] a;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rr(cdeleg_pkg::OFS_CTRL, 32'h6);
    rr(cdeleg_pkg::OFS_COUNTEREN, 32'h0);
    rr(8'h04, 32'h0);
    $display("test reset done");
    sel(64'h43);
    sr(3'h1, 1'b1, 64'h0);
    rw(cdeleg_pkg::OFS_CTRL, 32'h7);
    sr(3'h1, 1'b1, 64'h0);
    rw(cdeleg_pkg::OFS_COUNTEREN, 32'h9);
    rr(cdeleg_pkg::OFS_DELEGATED, 32'h9);
    sw(3'h1, 64'h1234_5678);
    sw(3'h4, 64'hAAAA_BBBB);
    sr(3'h1, 1'b0, 64'h1234_5678);
    sr(3'h4, 1'b0, 64'hAAAA_BBBB);
    sw(3'h5, 64'hFFFF_FFFF);
    sr(3'h5, 1'b0, 64'hBFFF_FFFF);
    sr(3'h3, 1'b1, 64'h0);
    sr(3'h6, 1'b1, 64'h0);
    sel(64'h44);
    sr(3'h1, 1'b1, 64'h0);
    sel(64'h40);
    sr(3'h2, 1'b1, 64'h0);
    sr(3'h1, 1'b0, 64'h0);
    $display("test windows done");
    rw(cdeleg_pkg::OFS_MINHIBIT, 32'hFFFF_FFFD);
    ck(cdeleg_pkg::TGT_SCINH, cdeleg_pkg::PRIV_S, 1'b0, 1'b0, 1'b0);
    chk("halt alias", 64'h9, r.rdata);
    ac(cdeleg_pkg::TGT_SCINH, 3'h0, cdeleg_pkg::PRIV_S, 1'b0, 1'b1, 64'h0);
    rr(cdeleg_pkg::OFS_MINHIBIT, 32'hFFFF_FFF4);
    ck(cdeleg_pkg::TGT_SCINH, cdeleg_pkg::PRIV_S, 1'b1, 1'b0, 1'b1);
    ck(cdeleg_pkg::TGT_SCOVF, cdeleg_pkg::PRIV_U, 1'b1, 1'b0, 1'b1);
    rw(cdeleg_pkg::OFS_COUNTEREN, 32'hB);
    sel(64'h41);
    sr(3'h1, 1'b1, 64'h0);
    $display("test halt done");
    rw(cdeleg_pkg::OFS_CTRL, 32'hF);
    sel(64'h43);
    sr(3'h4, 1'b1, 64'h0);
    ac(cdeleg_pkg::TGT_WIN, 3'h4, cdeleg_pkg::PRIV_S, 1'b0, 1'b1, 64'h5);
    tr(1'b1, 1'b0);
    sr(3'h5, 1'b1, 64'h0);
    sr(3'h1, 1'b0, 64'hAAAA_BBBB_1234_5678);
    sr(3'h2, 1'b0, 64'hBFFF_FFFF_0000_0000);
    sw(3'h2, 64'hC000_0000_0000_00A5);
    sr(3'h2, 1'b0, 64'h8000_0000_0000_00A5);
    ck(cdeleg_pkg::TGT_SCOVF, cdeleg_pkg::PRIV_S, 1'b0, 1'b0, 1'b0);
    chk("overflow view", 64'h8, r.rdata);
    rw(cdeleg_pkg::OFS_CTRL, 32'h5);
    sr(3'h1, 1'b1, 64'h0);
    rw(cdeleg_pkg::OFS_CTRL, 32'h6);
    ck(cdeleg_pkg::TGT_SCINH, cdeleg_pkg::PRIV_S, 1'b0, 1'b1, 1'b0);
    $display("test enables done");
    rw(cdeleg_pkg::OFS_CTRL, 32'h7);
    ac(cdeleg_pkg::TGT_VSEL, 3'h0, cdeleg_pkg::PRIV_M, 1'b0, 1'b1, 64'h43);
    ck(cdeleg_pkg::TGT_VWIN, cdeleg_pkg::PRIV_S, 1'b0, 1'b1, 1'b0);
    ck(cdeleg_pkg::TGT_WIN, cdeleg_pkg::PRIV_S, 1'b1, 1'b0, 1'b1);
    ck(cdeleg_pkg::TGT_VSEL, cdeleg_pkg::PRIV_S, 1'b1, 1'b0, 1'b1);
    ck(cdeleg_pkg::TGT_WIN, cdeleg_pkg::PRIV_U, 1'b1, 1'b0, 1'b1);
    rw(cdeleg_pkg::OFS_CTRL, 32'h6);
    ck(cdeleg_pkg::TGT_WIN, cdeleg_pkg::PRIV_S, 1'b1, 1'b1, 1'b0);
    $display("test guest done");
    for (int k = 0; k < cdeleg_pkg::OVF_IRQ_REGS; k++) begin
      a = cdeleg_pkg::OFS_OVF_IRQ_BASE + 8'(4 * k);
      rw(a, 32'hFFFF_FFFF);
      rr(a, k < 6 ? 32'h0000_2000 : 32'h0);
    end
    $display("test interrupt bits done");
    summarize();
  end
endmodule : tb_counter_delegation_access
